// file: logic/anp_map.svh
`ifndef ANP_MAP_SVH
`define ANP_MAP_SVH

// ------------------------------------------------------------
// register offsets on the management bus
// ------------------------------------------------------------
`define ANP_REG_ADV 5'h04
`define ANP_REG_EXP 5'h06
`define ANP_REG_NPTX 5'h07
`define ANP_REG_NPRX 5'h08

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ANP_ADV_NP_BIT 15
`define ANP_EXP_PDF_BIT 4
`define ANP_EXP_LPNP_BIT 3
`define ANP_EXP_NPABLE_BIT 2
`define ANP_EXP_PGRX_BIT 1
`define ANP_EXP_LPAN_BIT 0
`define ANP_NPTX_NP_BIT 15
`define ANP_NPTX_MP_BIT 13
`define ANP_NPTX_ACK2_BIT 12
`define ANP_NPTX_CODE_MSB 10

// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define ANP_NPTX_CODE_RST 11'h001
`define ANP_NPTX_MP_RST 1'b1
`define ANP_WORD_ZERO 16'h0000
`define ANP_NP_ABLE 1'b1

// ------------------------------------------------------------
// management frame figures
// ------------------------------------------------------------
`define ANP_OP_READ 2'h2
`define ANP_OP_WRITE 2'h1
`define ANP_PREAMBLE_MIN 6'h20
`define ANP_HDR_LAST 5'h0C
`define ANP_TA_LAST 5'h01
`define ANP_DATA_LAST 5'h0F
`define ANP_SKIP_LAST 5'h11

`endif

// file: logic/anp_mgmt_serial.sv
`timescale 1ns/10ps
`include "anp_map.svh"

module anp_mgmt_serial (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  output anp_pkg::anp_acc_t acc,
  input wire logic [15:0] rdata
);
  import anp_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers and clock edge detect
  // ------------------------------------------------------------
  logic mdc_m_q, mdc_s_q, mdc_p_q, dio_m_q, dio_s_q;
  // first stages feed only the second stages
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mdc_m_q <= 1'b0;
      mdc_s_q <= 1'b0;
      mdc_p_q <= 1'b0;
      dio_m_q <= 1'b1;
      dio_s_q <= 1'b1;
    end else begin
      mdc_m_q <= mdc;
      mdc_s_q <= mdc_m_q;
      mdc_p_q <= mdc_s_q;
      dio_m_q <= mdio_in;
      dio_s_q <= dio_m_q;
    end
  end

  wire rise = mdc_s_q & ~mdc_p_q;
  wire bit_in = dio_s_q;

  // ------------------------------------------------------------
  // frame decoder
  // ------------------------------------------------------------
  anp_mstate_t st_q;
  logic [5:0] ones_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic is_rd_q;
  logic [4:0] reg_q;

  wire [12:0] hdr = {sh_q[11:0], bit_in};
  wire hdr_ok = hdr[12] & (hdr[9:5] == phy_addr);
  wire hdr_rd = hdr_ok & (hdr[11:10] == `ANP_OP_READ);
  wire hdr_wr = hdr_ok & (hdr[11:10] == `ANP_OP_WRITE);
  wire hdr_end = rise & (st_q == ANP_HDR) & (cnt_q == `ANP_HDR_LAST);
  wire wr_end = rise & (st_q == ANP_WDATA) & (cnt_q == `ANP_DATA_LAST);

  // strobes are one core cycle; read data is taken in that same cycle
  assign acc.rd = hdr_end & hdr_rd;
  assign acc.wr = wr_end;
  assign acc.addr = hdr_end ? hdr[4:0] : reg_q;
  assign acc.wdata = {sh_q[14:0], bit_in};

  // all state moves on the synchronised mdc rising edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= ANP_IDLE;
      ones_q <= 6'h00;
      cnt_q <= 5'h00;
      sh_q <= `ANP_WORD_ZERO;
      is_rd_q <= 1'b0;
      reg_q <= 5'h00;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (rise) begin
      cnt_q <= cnt_q + 5'h01;
      unique case (st_q)
        ANP_IDLE: begin
          cnt_q <= 5'h00;
          if (bit_in) begin
            if (ones_q != `ANP_PREAMBLE_MIN) ones_q <= ones_q + 6'h01;
          end else if (ones_q == `ANP_PREAMBLE_MIN) begin
            st_q <= ANP_HDR;
          end else begin
            ones_q <= 6'h00;
          end
        end
        ANP_HDR: begin
          sh_q <= {sh_q[14:0], bit_in};
          ones_q <= 6'h00;
          if (cnt_q == `ANP_HDR_LAST) begin
            cnt_q <= 5'h00;
            reg_q <= hdr[4:0];
            is_rd_q <= hdr_rd;
            if (hdr_rd) sh_q <= rdata;
            st_q <= (hdr_rd | hdr_wr) ? ANP_TA : ANP_SKIP;
          end
        end
        ANP_TA: begin
          // second turnaround bit is driven low on reads
          if (is_rd_q) begin
            mdio_oe <= 1'b1;
            mdio_out <= (cnt_q == `ANP_TA_LAST) ? sh_q[15] : 1'b0;
          end
          if (cnt_q == `ANP_TA_LAST) begin
            cnt_q <= 5'h00;
            st_q <= is_rd_q ? ANP_RDATA : ANP_WDATA;
          end
        end
        ANP_RDATA: begin
          sh_q <= {sh_q[14:0], 1'b0};
          mdio_out <= sh_q[14];
          if (cnt_q == `ANP_DATA_LAST) begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
            st_q <= ANP_IDLE;
          end
        end
        ANP_WDATA: begin
          sh_q <= {sh_q[14:0], bit_in};
          if (cnt_q == `ANP_DATA_LAST) st_q <= ANP_IDLE;
        end
        ANP_SKIP: begin
          // foreign address or bad opcode: sit out the frame
          if (cnt_q == `ANP_SKIP_LAST) st_q <= ANP_IDLE;
        end
        default: st_q <= ANP_IDLE;
      endcase
    end
  end

endmodule : anp_mgmt_serial

// file: logic/anp_pkg.sv
package anp_pkg;

  // one next page word, transmit or received
  typedef struct packed {
    logic next_page;
    logic reserved;
    logic message_page;
    logic ack2;
    logic toggle;
    logic [10:0] code;
  } anp_page_t;

  // register access strobe from the serial engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } anp_acc_t;

  typedef enum logic [2:0] {
    ANP_IDLE = 3'b000,
    ANP_HDR = 3'b001,
    ANP_TA = 3'b010,
    ANP_RDATA = 3'b011,
    ANP_WDATA = 3'b100,
    ANP_SKIP = 3'b101
  } anp_mstate_t;

endpackage : anp_pkg

// file: logic/anp_regs.sv
`timescale 1ns/10ps
`include "anp_map.svh"

// Notes on behaviour
// - expansion register always reports local next-page capability as one
// - partner next-page and auto-negotiation ability bits are read-only, reset zero
// - parallel-fault and page-received flags latch high, read-only, reset zero
// - next-page, message-page and second acknowledge bits of outgoing page are read-write
// - outgoing toggle bit is device-kept, read-only, follows previous code word
// - outgoing eleven-bit code field is read-write, resets to one
// - partner's received next page is shown read-only, all bits reset zero
// - base advertisement next-page bit is read-write, resets zero, gates next-page offer

module anp_regs (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic parallel_fault,
  input wire logic partner_np_able,
  input wire logic partner_an_able,
  input wire logic page_rx,
  input wire anp_pkg::anp_page_t rx_page,
  input wire logic page_tx_sent,
  output anp_pkg::anp_page_t tx_page,
  output logic adv_next_page
);
  import anp_pkg::*;

  // ------------------------------------------------------------
  // management serial engine
  // ------------------------------------------------------------
  anp_acc_t acc;
  logic [15:0] rdata;

  anp_mgmt_serial u_serial (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .phy_addr(phy_addr),
    .acc(acc),
    .rdata(rdata)
  );

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire sel_adv = (acc.addr == `ANP_REG_ADV);
  wire sel_exp = (acc.addr == `ANP_REG_EXP);
  wire sel_nptx = (acc.addr == `ANP_REG_NPTX);
  wire sel_nprx = (acc.addr == `ANP_REG_NPRX);
  wire wr_adv = acc.wr & sel_adv;
  wire wr_nptx = acc.wr & sel_nptx;
  wire rd_exp = acc.rd & sel_exp;

  // ------------------------------------------------------------
  // stored state
  // ------------------------------------------------------------
  logic adv_np_q;
  logic pdf_q, pgrx_q, pgrx_arm_q;
  logic lp_np_q, lp_an_q;
  anp_page_t rxp_q;

  // base page next-page enable, writes to other base bits are not ours
  always_ff @(posedge core_clk) begin
    if (!rst_n) adv_np_q <= 1'b0;
    else if (wr_adv) adv_np_q <= acc.wdata[`ANP_ADV_NP_BIT];
  end
  assign adv_next_page = adv_np_q;

  // outgoing page: software fields, device-kept toggle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_page.next_page <= 1'b0;
      tx_page.reserved <= 1'b0;
      tx_page.message_page <= `ANP_NPTX_MP_RST;
      tx_page.ack2 <= 1'b0;
      tx_page.toggle <= 1'b0;
      tx_page.code <= `ANP_NPTX_CODE_RST;
    end else begin
      if (wr_nptx) begin
        tx_page.next_page <= acc.wdata[`ANP_NPTX_NP_BIT];
        tx_page.message_page <= acc.wdata[`ANP_NPTX_MP_BIT];
        tx_page.ack2 <= acc.wdata[`ANP_NPTX_ACK2_BIT];
        tx_page.code <= acc.wdata[`ANP_NPTX_CODE_MSB:0];
      end
      // toggle flips once per page put on the wire; software writes skip it
      if (page_tx_sent) tx_page.toggle <= ~tx_page.toggle;
    end
  end

  // partner page is captured one cycle before its flag rises
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxp_q <= `ANP_WORD_ZERO;
      pgrx_arm_q <= 1'b0;
      lp_np_q <= 1'b0;
      lp_an_q <= 1'b0;
    end else begin
      if (page_rx) rxp_q <= {rx_page.next_page, 1'b0, rx_page[13:0]};
      pgrx_arm_q <= page_rx;
      lp_np_q <= partner_np_able;
      lp_an_q <= partner_an_able;
    end
  end

  // latched-high flags: a new event in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pdf_q <= 1'b0;
      pgrx_q <= 1'b0;
    end else begin
      pdf_q <= parallel_fault | (pdf_q & ~rd_exp);
      pgrx_q <= pgrx_arm_q | (pgrx_q & ~rd_exp);
    end
  end

  // ------------------------------------------------------------
  // read mux, unmapped addresses read zero
  // ------------------------------------------------------------
  logic [15:0] exp_word;
  logic [15:0] adv_word;
  assign exp_word = {11'h000, pdf_q, lp_np_q, `ANP_NP_ABLE, pgrx_q, lp_an_q};
  assign adv_word = {adv_np_q, 15'h0000};
  assign rdata = sel_exp ? exp_word :
                 sel_nptx ? {tx_page.next_page, 1'b0, tx_page[13:0]} :
                 sel_nprx ? rxp_q :
                 sel_adv ? adv_word : `ANP_WORD_ZERO;

endmodule : anp_regs

// file: test/anp_regs_properties.sv
`timescale 1ns/10ps
module anp_regs_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic page_tx_sent,
  input wire anp_pkg::anp_page_t tx_page,
  input wire logic adv_next_page,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  import anp_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // pin moves must trail a fresh mdc rise, never the low half
  sequence s_after_rise;
    mdc && !$past(mdc, 7);
  endsequence
  // a read drives turnaround plus sixteen bits, far past eight cycles
  sequence s_burst;
    mdio_oe [*8];
  endsequence
  chk_tx_reset: assert property ($rose(rst_n) |-> tx_page == 16'h2001)
    else $error("tx page reset value wrong");
  chk_pin_reset: assert property ($rose(rst_n) |-> !mdio_oe && !mdio_out && !adv_next_page)
    else $error("outputs not idle after reset");
  chk_toggle_flip: assert property (page_tx_sent |=> tx_page.toggle != $past(tx_page.toggle))
    else $error("toggle did not flip");
  chk_toggle_hold: assert property (!page_tx_sent |=> $stable(tx_page.toggle))
    else $error("toggle moved without a sent page");
  chk_rsvd_zero: assert property (tx_page.reserved == 1'b0)
    else $error("reserved tx bit set");
  chk_drive_span: assert property ($rose(mdio_oe) |-> s_burst)
    else $error("read drive too short");
  chk_bit_align: assert property (mdio_oe && ($rose(mdio_oe) || $changed(mdio_out)) |-> s_after_rise)
    else $error("read bit moved off an mdc rise");
  chk_drive_end: assert property ($fell(mdio_oe) |-> s_after_rise)
    else $error("drive released off an mdc rise");
endmodule : anp_regs_properties

// file: test/anp_sta_model.sv
`timescale 1ns/10ps
module anp_sta_model (
  input wire logic core_clk,
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic sta_q = 1'b1;
  logic [15:0] rd_q;
  event done;
  // device level when it drives, else ours or the pull-up
  assign mdio_in = mdio_oe ? mdio_out : sta_q;
  initial mdc = 1'b0;
  // one frame; mdc stands low between frames, line released high
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    for (int k = 63; k >= 0; k--) begin
      mdc = 1'b0;
      sta_q = (op == 2'h2 && k < 18) ? 1'b1 : bits[k]; // reads leave turnaround to the device
      repeat (8) @(posedge core_clk);
      #1 rd_q = {rd_q[14:0], mdio_in};
      mdc = 1'b1;
      repeat (8) @(posedge core_clk);
      #1;
    end
    mdc = 1'b0;
    sta_q = 1'b1;
    if (op == 2'h2)
      ->done;
  endtask : frame
endmodule : anp_sta_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import anp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mdc, mdio_in, mdio_out, mdio_oe, adv_next_page;
  logic parallel_fault = 1'b0;
  logic partner_np_able = 1'b0;
  logic partner_an_able = 1'b0;
  logic page_rx = 1'b0;
  logic page_tx_sent = 1'b0;
  logic [4:0] phy_addr = 5'h0B;
  anp_page_t rx_page = 16'h0000;
  anp_page_t tx_page;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h22E4;
  int error_cnt = 0;
  int comparisons = 0;
  // 25 MHz core clock
  initial forever #20 core_clk = ~core_clk;
  anp_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(phy_addr), .parallel_fault(parallel_fault), .partner_np_able(partner_np_able),
    .partner_an_able(partner_an_able), .page_rx(page_rx), .rx_page(rx_page), .page_tx_sent(page_tx_sent),
    .tx_page(tx_page), .adv_next_page(adv_next_page));
  anp_sta_model sta_u (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic st(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : st
  // one access; for a read the last argument is the expected word
  task automatic mx(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] d);
    if (op == 2'h2)
      exp_q.push_back(d);
    sta_u.frame(op, phy_addr, ra, d);
  endtask : mx
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : xs
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // each finished read is matched against the oldest note
  initial forever begin
    @(sta_u.done);
    chk(sta_u.rd_q, exp_q.pop_front());
  end
  // 34 frames of 1024 cycles; a hang stops well past that
  initial begin
    st(60000);
    error_cnt++;
    conclude();
  end
  initial begin
    logic [15:0] w;
    st(20);
    rst_n = 1'b1;
    st(4);
    mx(2'h2, 5'h04, 16'h0000);
    mx(2'h2, 5'h06, 16'h0004);
    mx(2'h2, 5'h07, 16'h2001);
    mx(2'h2, 5'h08, 16'h0000);
    mx(2'h2, 5'h0A, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      w = xs();
      mx(2'h1, 5'h07, w);
      mx(2'h1, 5'h06, ~w);
      mx(2'h1, 5'h08, w);
      mx(2'h2, 5'h07, w & 16'hB7FF);
    end
    mx(2'h2, 5'h08, 16'h0000);
    mx(2'h1, 5'h04, 16'hFFFF);
    chk({15'h0000, adv_next_page}, 16'h0001);
    page_tx_sent = 1'b1;
    st(1);
    page_tx_sent = 1'b0;
    mx(2'h2, 5'h07, (w & 16'hB7FF) | 16'h0800);
    mx(2'h1, 5'h07, 16'h0000);
    chk(tx_page, 16'h0800);
    mx(2'h2, 5'h07, 16'h0800);
    $display("test writes and toggle done");
    partner_np_able = 1'b1;
    partner_an_able = 1'b1;
    rx_page = xs();
    page_rx = 1'b1;
    st(1);
    page_rx = 1'b0;
    w = rx_page & 16'hBFFF;
    rx_page = ~rx_page;
    mx(2'h2, 5'h08, w);
    mx(2'h2, 5'h06, 16'h000F);
    for (int i = 0; i < 5; i++) begin
      parallel_fault = (i > 0 && i < 3);
      mx(2'h2, 5'h06, (i > 0 && i < 4) ? 16'h001D : 16'h000D);
    end
    $display("test events done");
    exp_q.push_back(16'hFFFF);
    sta_u.frame(2'h2, phy_addr ^ 5'h01, 5'h07, 16'h0000);
    sta_u.frame(2'h1, phy_addr ^ 5'h01, 5'h04, 16'h0000);
    // our address but an opcode that is neither read nor write: must not land
    sta_u.frame(2'h3, phy_addr, 5'h04, 16'h0000);
    mx(2'h2, 5'h04, 16'h8000);
    rst_n = 1'b0;
    st(20);
    rst_n = 1'b1;
    st(4);
    mx(2'h2, 5'h07, 16'h2001);
    $display("test refusal and reset done");
    st(2);
    conclude();
  end
endmodule : testbench
bind anp_regs anp_regs_properties chk_u (.core_clk(core_clk), .rst_n(rst_n), .mdc(mdc),
  .page_tx_sent(page_tx_sent), .tx_page(tx_page), .adv_next_page(adv_next_page), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe));
